// File: iord_cfg.svh
// Constants for the I/O register space decode: offsets, field positions,
// bit masks and reset values. Included only by the package; the design modules use its macros without including it.
//
// Contract
// RULE1: Software writes zero into reserved bit positions of any register it accesses.
// RULE2: The core never writes to an I/O address marked reserved.
// RULE3: Single-bit set and clear work only on I/O addresses 0x00 to 0x1F.
// RULE4: Skip instructions test one bit of registers in the lower 32 addresses.
// RULE5: Status flags clear on a written one; a written zero leaves them alone.
// RULE6: Single-bit set or clear touches only the addressed bit, no write-back.
// RULE7: I/O input and output instructions use I/O addresses 0x00 to 0x3F.
// RULE8: Data-space loads and stores see each register at I/O address plus 0x20.
// RULE9: Reserved bits and addresses read zero; writes to them change nothing.
`ifndef IORD_CFG_SVH
`define IORD_CFG_SVH

// Address windows and the register reset value
`define IORD_DS_OFS 8'h20
`define IORD_DS_TOP 8'h5F
`define IORD_BIT_TOP 8'h1F
`define IORD_RST_VAL 8'h00

// Register indices in the lower half
`define IORD_A_UNUSED 5'h00
`define IORD_A_DIN_DIS 5'h01
`define IORD_A_BAUD_HI 5'h02
`define IORD_A_FRAME 5'h03
`define IORD_A_RSVD_LO 5'h04
`define IORD_A_RSVD_HI 5'h07
`define IORD_A_CMP 5'h08
`define IORD_A_BAUD_LO 5'h09
`define IORD_A_UART_EN 5'h0A
`define IORD_A_UART_ST 5'h0B
`define IORD_A_UART_DATA 5'h0C
`define IORD_A_SER_CTL 5'h0D
`define IORD_A_SER_ST 5'h0E
`define IORD_A_SER_DATA 5'h0F
`define IORD_A_PD_PIN 5'h10
`define IORD_A_PD_DIR 5'h11
`define IORD_A_PD_OUT 5'h12
`define IORD_A_SCR0 5'h13
`define IORD_A_SCR2 5'h15
`define IORD_A_PB_PIN 5'h16
`define IORD_A_PB_DIR 5'h17
`define IORD_A_PB_OUT 5'h18
`define IORD_A_PA_PIN 5'h19
`define IORD_A_PA_DIR 5'h1A
`define IORD_A_PA_OUT 5'h1B

// Field positions
`define IORD_B_UART_TXDONE 6
`define IORD_B_UART_RX9 1
`define IORD_B_SER_START 7
`define IORD_B_SER_OVF 6
`define IORD_B_SER_STOP 5
`define IORD_B_SER_COLL 4
`define IORD_B_CMP_OUT 5
`define IORD_B_CMP_EDGE 4

// Implemented bit masks
`define IORD_M_PA 8'h07
`define IORD_M_PD 8'h7F
`define IORD_M_FULL 8'hFF
`define IORD_M_DIN_DIS 8'h03
`define IORD_M_BAUD_HI 8'h0F
`define IORD_M_FRAME 8'h7F
`define IORD_RW_UART_ST 8'h03
`define IORD_W1_UART_ST 8'h40
`define IORD_RO_UART_ST 8'hBC
`define IORD_RW_UART_EN 8'hFD
`define IORD_RO_UART_EN 8'h02
`define IORD_RW_SER_ST 8'h0F
`define IORD_W1_SER_ST 8'hE0
`define IORD_RO_SER_ST 8'h10
`define IORD_RW_CMP 8'hCF
`define IORD_W1_CMP 8'h10
`define IORD_RO_CMP 8'h20

`endif

// File: iord_pkg.sv
// Types shared by the I/O register space decode modules.
// Assumes iord_cfg.svh is on the include path.
package iord_pkg;
`include "iord_cfg.svh"

   // Operation presented by the core each cycle
   typedef enum logic [3:0] {
      IORD_OP_NONE = 4'h0,
      IORD_OP_IN = 4'h1,
      IORD_OP_OUT = 4'h2,
      IORD_OP_LOAD = 4'h3,
      IORD_OP_STORE = 4'h4,
      IORD_OP_SET = 4'h5,
      IORD_OP_CLEAR = 4'h6,
      IORD_OP_SKIP_ONE = 4'h7,
      IORD_OP_SKIP_ZERO = 4'h8
   } iord_op_type;

   typedef logic [4:0] iord_idx_type;
endpackage : iord_pkg

// File: iord_acc_if.sv
// Decoded access passed from the address decoder to the register bank.
// Both ends sit on the core clock; signals are combinational.
`timescale 1ns/1ps
interface iord_acc_if;
   import iord_pkg::*;
   logic rd;
   logic wr;
   logic bit_op;
   logic bit_val;
   logic skip;
   logic skip_val;
   logic lower;
   logic err;
   iord_idx_type idx;
   logic [2:0] bit_sel;
   logic [7:0] wdata;
   modport dec (output rd, wr, bit_op, bit_val, skip, skip_val, lower, err, idx, bit_sel, wdata);
   modport bank (input rd, wr, bit_op, bit_val, skip, skip_val, lower, err, idx, bit_sel, wdata);
endinterface : iord_acc_if

// File: iord_decode.sv
// Address decoder: folds I/O and data-space addressing into one index.
// Assumes one operation per cycle from the core.
`timescale 1ns/1ps
module iord_decode
   import iord_pkg::*;
(
   // Core request
   input wire iord_op_type op_i,
   input wire logic [7:0] addr_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [7:0] wdata_i,
   // Decoded access
   iord_acc_if.dec acc
);
   logic is_ds, ds_hit, valid, lower, rsvd, is_read, is_write, is_bit, is_skip;
   logic [7:0] ds_io;
   logic [5:0] io_addr;

   // Data space sits 0x20 above the I/O address
   assign is_ds = (op_i == IORD_OP_LOAD) || (op_i == IORD_OP_STORE);
   assign ds_hit = (addr_i >= `IORD_DS_OFS) && (addr_i <= `IORD_DS_TOP); // RULE8
   assign ds_io = addr_i - `IORD_DS_OFS; // RULE8
   assign io_addr = is_ds ? ds_io[5:0] : addr_i[5:0]; // RULE7
   assign valid = is_ds ? ds_hit : (op_i != IORD_OP_NONE);
   assign lower = valid && ({2'b00, io_addr} <= `IORD_BIT_TOP);
   assign rsvd = (io_addr[4:0] == `IORD_A_UNUSED) ||
                 ((io_addr[4:0] >= `IORD_A_RSVD_LO) && (io_addr[4:0] <= `IORD_A_RSVD_HI));

   // Operation classes
   assign is_read = (op_i == IORD_OP_IN) || (op_i == IORD_OP_LOAD);
   assign is_write = (op_i == IORD_OP_OUT) || (op_i == IORD_OP_STORE);
   assign is_bit = (op_i == IORD_OP_SET) || (op_i == IORD_OP_CLEAR);
   assign is_skip = (op_i == IORD_OP_SKIP_ONE) || (op_i == IORD_OP_SKIP_ZERO);

   // Upper half lies outside this bank: writes there are not ours to take
   assign acc.rd = valid && is_read;
   assign acc.wr = lower && !rsvd && is_write; // RULE9
   assign acc.bit_op = lower && !rsvd && is_bit; // RULE3
   assign acc.skip = valid && is_skip;
   assign acc.lower = lower;
   assign acc.err = (lower && rsvd && (is_write || is_bit)) || (valid && !lower && (is_bit || is_skip)); // RULE2
   assign acc.idx = io_addr[4:0];
   assign acc.bit_sel = bit_sel_i;
   assign acc.bit_val = (op_i == IORD_OP_SET);
   assign acc.skip_val = (op_i == IORD_OP_SKIP_ONE);
   assign acc.wdata = wdata_i;
endmodule : iord_decode

// File: iord_reg8.sv
// One 8-bit register with read-write and write-one-to-clear fields.
// Hardware set events override a clear in the same cycle.
`timescale 1ns/1ps
module iord_reg8 #(
   parameter logic [7:0] RW_MASK = 8'h00,
   parameter logic [7:0] W1C_MASK = 8'h00
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Access
   input wire logic wr_i,
   input wire logic [7:0] data_i,
   input wire logic bit_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic bit_val_i,
   input wire logic [7:0] set_i,
   // Stored value
   output logic [7:0] q_o
);
   logic [7:0] onehot, full_d, bit_d, q_d;

   // Bit ops build their own mask so no other field is written back
   assign onehot = 8'h01 << bit_sel_i; // RULE6
   assign full_d = ((data_i & RW_MASK) | (q_o & ~RW_MASK)) & ~(data_i & W1C_MASK); // RULE5
   assign bit_d = bit_val_i ? ((q_o | (onehot & RW_MASK)) & ~(onehot & W1C_MASK)) :
                  (q_o & ~(onehot & RW_MASK)); // RULE6
   assign q_d = ((wr_i ? full_d : (bit_i ? bit_d : q_o)) | (set_i & W1C_MASK)) & (RW_MASK | W1C_MASK); // RULE9

   // Storage
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         q_o <= `IORD_RST_VAL;
      end else begin
         q_o <= q_d;
      end
   end
endmodule : iord_reg8

// File: iord_top.sv
// Lower half of the I/O register space: ports, scratch, serial, UART,
// comparator registers, with byte, single-bit and skip-test access.
// Assumes the core presents one operation per cycle on the core clock.
`timescale 1ns/1ps
module iord_top
   import iord_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Core request
   input wire iord_op_type op_i,
   input wire logic [7:0] addr_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [7:0] wdata_i,
   // Core answers
   output logic [7:0] rdata_o,
   output logic rdata_valid_o,
   output logic skip_o,
   output logic skip_valid_o,
   output logic access_error_o,
   // Parallel port A
   input wire logic [2:0] port_a_pins_i,
   output logic [2:0] port_a_out_o,
   output logic [2:0] port_a_dir_o,
   // Parallel port B
   input wire logic [7:0] port_b_pins_i,
   output logic [7:0] port_b_out_o,
   output logic [7:0] port_b_dir_o,
   // Parallel port D
   input wire logic [6:0] port_d_pins_i,
   output logic [6:0] port_d_out_o,
   output logic [6:0] port_d_dir_o,
   // UART
   input wire logic [7:0] uart_rx_data_i,
   input wire logic [7:0] uart_status_i,
   input wire logic uart_rx_bit8_i,
   input wire logic uart_tx_done_i,
   output logic [11:0] uart_baud_o,
   output logic [7:0] uart_frame_o,
   output logic [7:0] uart_enable_o,
   output logic [1:0] uart_mode_o,
   output logic uart_tx_flag_o,
   output logic [7:0] uart_tx_data_o,
   output logic uart_tx_write_o,
   output logic uart_rx_read_o,
   // Serial shift interface
   input wire logic serial_start_i,
   input wire logic serial_overflow_i,
   input wire logic serial_stop_i,
   input wire logic serial_collision_i,
   output logic [7:0] serial_control_o,
   output logic [3:0] serial_count_o,
   output logic [2:0] serial_flags_o,
   output logic [7:0] serial_data_o,
   // Comparator and input disable
   input wire logic cmp_out_i,
   input wire logic cmp_edge_i,
   output logic [7:0] cmp_control_o,
   output logic [1:0] digital_input_disable_o
);

   // Read-write field mask of each index
   function automatic logic [7:0] rw_mask(input iord_idx_type idx);
      case (idx)
         `IORD_A_DIN_DIS: rw_mask = `IORD_M_DIN_DIS;
         `IORD_A_BAUD_HI: rw_mask = `IORD_M_BAUD_HI;
         `IORD_A_FRAME: rw_mask = `IORD_M_FRAME;
         `IORD_A_CMP: rw_mask = `IORD_RW_CMP;
         `IORD_A_UART_EN: rw_mask = `IORD_RW_UART_EN;
         `IORD_A_UART_ST: rw_mask = `IORD_RW_UART_ST;
         `IORD_A_SER_ST: rw_mask = `IORD_RW_SER_ST;
         `IORD_A_PA_DIR, `IORD_A_PA_OUT: rw_mask = `IORD_M_PA;
         `IORD_A_PD_DIR, `IORD_A_PD_OUT: rw_mask = `IORD_M_PD;
         `IORD_A_BAUD_LO, `IORD_A_UART_DATA, `IORD_A_SER_CTL, `IORD_A_SER_DATA,
         `IORD_A_PB_DIR, `IORD_A_PB_OUT: rw_mask = `IORD_M_FULL;
         default: rw_mask = ((idx >= `IORD_A_SCR0) && (idx <= `IORD_A_SCR2)) ? `IORD_M_FULL : 8'h00;
      endcase
   endfunction : rw_mask

   // Write-one-to-clear flag mask of each index
   function automatic logic [7:0] w1c_mask(input iord_idx_type idx);
      case (idx)
         `IORD_A_UART_ST: w1c_mask = `IORD_W1_UART_ST;
         `IORD_A_SER_ST: w1c_mask = `IORD_W1_SER_ST;
         `IORD_A_CMP: w1c_mask = `IORD_W1_CMP;
         default: w1c_mask = 8'h00;
      endcase
   endfunction : w1c_mask

   // Read-only live field mask of each index
   function automatic logic [7:0] ro_mask(input iord_idx_type idx);
      case (idx)
         `IORD_A_PA_PIN: ro_mask = `IORD_M_PA;
         `IORD_A_PD_PIN: ro_mask = `IORD_M_PD;
         `IORD_A_PB_PIN, `IORD_A_UART_DATA: ro_mask = `IORD_M_FULL;
         `IORD_A_UART_ST: ro_mask = `IORD_RO_UART_ST;
         `IORD_A_UART_EN: ro_mask = `IORD_RO_UART_EN;
         `IORD_A_SER_ST: ro_mask = `IORD_RO_SER_ST;
         `IORD_A_CMP: ro_mask = `IORD_RO_CMP;
         default: ro_mask = 8'h00;
      endcase
   endfunction : ro_mask

   iord_acc_if acc ();
   logic [7:0] q [0:31];
   logic [7:0] rd_val [0:31];
   logic [7:0] ro_in [0:31];
   logic [7:0] ev_in [0:31];
   logic [7:0] sel_val, rdata_d;
   logic sel_bit, skip_d, tx_wr_d, rx_rd_d;
   logic rdata_valid_q, skip_q, skip_valid_q, err_q, tx_wr_q, rx_rd_q;
   logic [7:0] rdata_q;

   // Address decode for both I/O and data-space windows
   iord_decode u_decode (
      .op_i (op_i),
      .addr_i (addr_i),
      .bit_sel_i (bit_sel_i),
      .wdata_i (wdata_i),
      .acc (acc)
   );

   // Register bank; unused indices collapse to constant zero
   for (genvar g = 0; g < 32; g++) begin : g_reg
      localparam iord_idx_type IDX = 5'(g);
      localparam logic [7:0] RW = rw_mask(IDX);
      localparam logic [7:0] W1C = w1c_mask(IDX);
      localparam logic [7:0] RO = ro_mask(IDX);
      // The data buffer reads the receive side, never the transmit byte
      localparam logic [7:0] RDQ = (IDX == `IORD_A_UART_DATA) ? 8'h00 : (RW | W1C);
      logic sel;

      assign sel = (acc.idx == IDX);
      // Live inputs placed at their field positions
      assign ro_in[g] = (IDX == `IORD_A_PA_PIN) ? {5'h00, port_a_pins_i} :
                        (IDX == `IORD_A_PB_PIN) ? port_b_pins_i :
                        (IDX == `IORD_A_PD_PIN) ? {1'b0, port_d_pins_i} :
                        (IDX == `IORD_A_UART_DATA) ? uart_rx_data_i :
                        (IDX == `IORD_A_UART_ST) ? uart_status_i :
                        (IDX == `IORD_A_UART_EN) ? ({7'h00, uart_rx_bit8_i} << `IORD_B_UART_RX9) :
                        (IDX == `IORD_A_SER_ST) ? ({7'h00, serial_collision_i} << `IORD_B_SER_COLL) :
                        (IDX == `IORD_A_CMP) ? ({7'h00, cmp_out_i} << `IORD_B_CMP_OUT) : 8'h00;
      // Peripheral events that raise sticky flags
      assign ev_in[g] = (IDX == `IORD_A_UART_ST) ? ({7'h00, uart_tx_done_i} << `IORD_B_UART_TXDONE) :
                        (IDX == `IORD_A_SER_ST) ? (({7'h00, serial_start_i} << `IORD_B_SER_START) |
                                                   ({7'h00, serial_overflow_i} << `IORD_B_SER_OVF) |
                                                   ({7'h00, serial_stop_i} << `IORD_B_SER_STOP)) :
                        (IDX == `IORD_A_CMP) ? ({7'h00, cmp_edge_i} << `IORD_B_CMP_EDGE) : 8'h00;

      iord_reg8 #(
         .RW_MASK (RW),
         .W1C_MASK (W1C)
      ) u_reg (
         .clock_i (clock_i),
         .rst_i (rst_i),
         .wr_i (acc.wr && sel),
         .data_i (acc.wdata),
         .bit_i (acc.bit_op && sel),
         .bit_sel_i (acc.bit_sel),
         .bit_val_i (acc.bit_val),
         .set_i (ev_in[g]),
         .q_o (q[g])
      );
      // Reserved bits and slots have empty masks and read zero
      assign rd_val[g] = (q[g] & RDQ) | (ro_in[g] & RO); // RULE9
   end

   // Read and skip selection
   assign sel_val = rd_val[acc.idx];
   assign sel_bit = sel_val[acc.bit_sel];
   assign rdata_d = acc.lower ? sel_val : 8'h00; // RULE7
   assign skip_d = acc.lower && (sel_bit == acc.skip_val); // RULE4
   assign tx_wr_d = (acc.wr || acc.bit_op) && (acc.idx == `IORD_A_UART_DATA);
   assign rx_rd_d = acc.rd && acc.lower && (acc.idx == `IORD_A_UART_DATA);

   // Answer flops; every answer lands one edge after the request
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
         rdata_valid_q <= 1'b0;
         skip_q <= 1'b0;
         skip_valid_q <= 1'b0;
         err_q <= 1'b0;
         tx_wr_q <= 1'b0;
         rx_rd_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rdata_valid_q <= acc.rd;
         skip_q <= acc.skip && skip_d;
         skip_valid_q <= acc.skip;
         err_q <= acc.err;
         tx_wr_q <= tx_wr_d;
         rx_rd_q <= rx_rd_d;
      end
   end

   // Core answers
   assign rdata_o = rdata_q;
   assign rdata_valid_o = rdata_valid_q;
   assign skip_o = skip_q;
   assign skip_valid_o = skip_valid_q;
   assign access_error_o = err_q;

   // Peripheral controls, taken from register flops
   assign port_a_out_o = q[`IORD_A_PA_OUT][2:0];
   assign port_a_dir_o = q[`IORD_A_PA_DIR][2:0];
   assign port_b_out_o = q[`IORD_A_PB_OUT];
   assign port_b_dir_o = q[`IORD_A_PB_DIR];
   assign port_d_out_o = q[`IORD_A_PD_OUT][6:0];
   assign port_d_dir_o = q[`IORD_A_PD_DIR][6:0];
   assign uart_baud_o = {q[`IORD_A_BAUD_HI][3:0], q[`IORD_A_BAUD_LO]};
   assign uart_frame_o = q[`IORD_A_FRAME];
   assign uart_enable_o = q[`IORD_A_UART_EN];
   assign uart_mode_o = q[`IORD_A_UART_ST][1:0];
   assign uart_tx_flag_o = q[`IORD_A_UART_ST][`IORD_B_UART_TXDONE];
   assign uart_tx_data_o = q[`IORD_A_UART_DATA];
   assign uart_tx_write_o = tx_wr_q;
   assign uart_rx_read_o = rx_rd_q;
   assign serial_control_o = q[`IORD_A_SER_CTL];
   assign serial_count_o = q[`IORD_A_SER_ST][3:0];
   assign serial_flags_o = q[`IORD_A_SER_ST][7:5];
   assign serial_data_o = q[`IORD_A_SER_DATA];
   assign cmp_control_o = q[`IORD_A_CMP];
   assign digital_input_disable_o = q[`IORD_A_DIN_DIS][1:0];

   // Checks on the bank as seen from the core
   sequence s_in_port_b;
      op_i == IORD_OP_IN && addr_i == {3'h0, `IORD_A_PB_OUT};
   endsequence
   sequence s_load_port_b;
      op_i == IORD_OP_LOAD && addr_i == ({3'h0, `IORD_A_PB_OUT} + `IORD_DS_OFS);
   endsequence
   sequence s_store_dir_b;
      op_i == IORD_OP_STORE && addr_i == ({3'h0, `IORD_A_PB_DIR} + `IORD_DS_OFS);
   endsequence
   sequence s_out_uart_st;
      op_i == IORD_OP_OUT && addr_i == {3'h0, `IORD_A_UART_ST};
   endsequence
   sequence s_set_uart_mode;
      op_i == IORD_OP_SET && addr_i == {3'h0, `IORD_A_UART_ST} && bit_sel_i == 3'h0;
   endsequence

   property p_io_read;
      @(posedge clock_i) disable iff (rst_i)
      s_in_port_b |=> rdata_valid_o && rdata_o == $past(port_b_out_o);
   endproperty
   a_io_read: assert property (p_io_read) else $error("I/O read of port B latch wrong"); // RULE7

   property p_ds_read;
      @(posedge clock_i) disable iff (rst_i)
      s_load_port_b |=> rdata_valid_o && rdata_o == $past(port_b_out_o);
   endproperty
   a_ds_read: assert property (p_ds_read) else $error("Data-space load of port B latch wrong"); // RULE8

   property p_ds_store;
      @(posedge clock_i) disable iff (rst_i)
      s_store_dir_b ##1 (op_i == IORD_OP_NONE) |-> port_b_dir_o == $past(wdata_i) ##1 port_b_dir_o == $past(wdata_i, 2);
   endproperty
   a_ds_store: assert property (p_ds_store) else $error("Data-space store missed direction register"); // RULE8

   property p_bit_high;
      @(posedge clock_i) disable iff (rst_i)
      (op_i == IORD_OP_SET || op_i == IORD_OP_CLEAR) && addr_i[5] |=>
         access_error_o && $stable(port_a_out_o) && $stable(port_b_out_o) && $stable(port_d_out_o);
   endproperty
   a_bit_high: assert property (p_bit_high) else $error("Bit op above 0x1F took effect"); // RULE3

   property p_skip_one;
      @(posedge clock_i) disable iff (rst_i)
      op_i == IORD_OP_SKIP_ONE && addr_i[5] == 1'b0 |=> skip_valid_o && skip_o == $past(sel_bit);
   endproperty
   a_skip_one: assert property (p_skip_one) else $error("Skip-if-one result wrong"); // RULE4

   property p_skip_zero;
      @(posedge clock_i) disable iff (rst_i)
      op_i == IORD_OP_SKIP_ZERO && addr_i[5] == 1'b0 |=> skip_valid_o && skip_o == !$past(sel_bit);
   endproperty
   a_skip_zero: assert property (p_skip_zero) else $error("Skip-if-zero result wrong"); // RULE4

   property p_w1c_clear;
      @(posedge clock_i) disable iff (rst_i)
      s_out_uart_st and (wdata_i[`IORD_B_UART_TXDONE] && !uart_tx_done_i) |=> !uart_tx_flag_o;
   endproperty
   a_w1c_clear: assert property (p_w1c_clear) else $error("Written one did not clear flag"); // RULE5

   property p_w0_keep;
      @(posedge clock_i) disable iff (rst_i)
      s_out_uart_st and (!wdata_i[`IORD_B_UART_TXDONE] && uart_tx_flag_o) |=> uart_tx_flag_o;
   endproperty
   a_w0_keep: assert property (p_w0_keep) else $error("Written zero changed flag"); // RULE5

   property p_set_wins;
      @(posedge clock_i) disable iff (rst_i)
      s_out_uart_st and (wdata_i[`IORD_B_UART_TXDONE] && uart_tx_done_i) |=> uart_tx_flag_o;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("Flag event lost to clear"); // RULE5

   property p_bit_only;
      @(posedge clock_i) disable iff (rst_i)
      s_set_uart_mode and uart_tx_flag_o |=> uart_tx_flag_o && uart_mode_o[0] && $stable(uart_mode_o[1]);
   endproperty
   a_bit_only: assert property (p_bit_only) else $error("Bit set disturbed other bits"); // RULE6

   property p_rsvd_read;
      @(posedge clock_i) disable iff (rst_i)
      op_i == IORD_OP_IN && addr_i[5:2] == 4'h1 |=> rdata_valid_o && rdata_o == 8'h00;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read) else $error("Reserved slot read nonzero"); // RULE9

   property p_rx_read;
      @(posedge clock_i) disable iff (rst_i)
      op_i == IORD_OP_IN && addr_i == {3'h0, `IORD_A_UART_DATA} |=> uart_rx_read_o && rdata_o == $past(uart_rx_data_i);
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("Receive byte read wrong"); // RULE7

   property p_tx_write;
      @(posedge clock_i) disable iff (rst_i)
      op_i == IORD_OP_OUT && addr_i == {3'h0, `IORD_A_UART_DATA} |=> uart_tx_write_o && uart_tx_data_o == $past(wdata_i);
   endproperty
   a_tx_write: assert property (p_tx_write) else $error("Transmit byte write wrong"); // RULE7

   property p_rsvd_write;
      @(posedge clock_i) disable iff (rst_i)
      op_i == IORD_OP_OUT && addr_i[5:2] == 4'h1 |=> access_error_o;
   endproperty
   a_rsvd_write: assert property (p_rsvd_write) else $error("Reserved slot write not flagged"); // RULE2

   // Port D has no bit 7, so that bit is left out
   property p_set_pd;
      @(posedge clock_i) disable iff (rst_i)
      op_i == IORD_OP_SET && addr_i == {3'h0, `IORD_A_PD_OUT} && bit_sel_i != 3'h7 |=>
         (({1'b0, port_d_out_o} >> $past(bit_sel_i)) & 8'h01) == 8'h01;
   endproperty
   a_set_pd: assert property (p_set_pd) else $error("Bit set on port D latch lost"); // RULE3

   property p_idle_quiet;
      @(posedge clock_i) disable iff (rst_i)
      op_i == IORD_OP_NONE |=> !rdata_valid_o && !skip_valid_o && !access_error_o;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("Answer without request"); // RULE7

   property p_ds_range;
      @(posedge clock_i) disable iff (rst_i)
      op_i == IORD_OP_LOAD && (addr_i < `IORD_DS_OFS || addr_i > `IORD_DS_TOP) |=> !rdata_valid_o;
   endproperty
   a_ds_range: assert property (p_ds_range) else $error("Load outside alias answered"); // RULE8

endmodule : iord_top

// File: iord_core_model.sv
// Core model: issues one I/O operation per cycle toward the decode block.
// Assumes the block samples requests on the rising clock edge.
`timescale 1ns/1ps
module iord_core_model
   import iord_pkg::*;
(
   // Clock
   input wire logic clock_i,
   // Request to the block
   output iord_op_type op_o,
   output logic [7:0] addr_o,
   output logic [2:0] bit_sel_o,
   output logic [7:0] wdata_o
);
   // Idle request at time zero
   initial begin
      op_o = IORD_OP_NONE;
      addr_o = 8'h00;
      bit_sel_o = 3'h0;
      wdata_o = 8'h00;
   end

   // Drive off the sampling edge; idle cycles flip the address and write-data lines
   task automatic io(input iord_op_type op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
      @(negedge clock_i);
      op_o = op;
      addr_o = (op == IORD_OP_NONE) ? ~addr_o : a;
      bit_sel_o = b;
      wdata_o = (op == IORD_OP_NONE) ? ~wdata_o : d;
   endtask : io
endmodule : iord_core_model

// File: tb_iord_top.sv
// Bench for the I/O register space decode: byte, bit and skip access.
// Assumes the core model issues requests at the falling clock edge.
`timescale 1ns/1ps
module tb_iord_top;
   import iord_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   iord_op_type op;
   logic [7:0] addr, wdata, rdata, pb_out, pb_dir, tx_data;
   logic [7:0] pins_b = 8'hA5;
   logic [2:0] bsel, pa_out;
   logic [6:0] pd_out;
   logic [4:0] ev = 5'h00;
   logic rvalid, skip, svalid, aerr, tx_flag;
   logic [7:0] flag_addr [5] = '{8'h0B, 8'h0E, 8'h0E, 8'h0E, 8'h08};
   logic [2:0] flag_bit [5] = '{3'h6, 3'h7, 3'h6, 3'h5, 3'h4};
   int num_errors = 0;
   int samples_checked = 0;

   // 25 ns core clock
   always #12.5 clock_i = ~clock_i;

   iord_core_model u_core (.clock_i(clock_i), .op_o(op), .addr_o(addr), .bit_sel_o(bsel), .wdata_o(wdata));

   iord_top u_dut (.clock_i(clock_i), .rst_i(rst_i), .op_i(op), .addr_i(addr), .bit_sel_i(bsel),
      .wdata_i(wdata), .rdata_o(rdata), .rdata_valid_o(rvalid), .skip_o(skip), .skip_valid_o(svalid),
      .access_error_o(aerr), .port_a_pins_i(pins_b[2:0]), .port_a_out_o(pa_out), .port_a_dir_o(),
      .port_b_pins_i(pins_b), .port_b_out_o(pb_out), .port_b_dir_o(pb_dir), .port_d_pins_i(pins_b[6:0]),
      .port_d_out_o(pd_out), .port_d_dir_o(), .uart_rx_data_i(~pins_b), .uart_status_i(8'h00),
      .uart_rx_bit8_i(1'b0), .uart_tx_done_i(ev[0]), .uart_baud_o(), .uart_frame_o(), .uart_enable_o(),
      .uart_mode_o(), .uart_tx_flag_o(tx_flag), .uart_tx_data_o(tx_data), .uart_tx_write_o(), .uart_rx_read_o(),
      .serial_start_i(ev[1]), .serial_overflow_i(ev[2]), .serial_stop_i(ev[3]), .serial_collision_i(1'b0),
      .serial_control_o(), .serial_count_o(), .serial_flags_o(), .serial_data_o(), .cmp_out_i(1'b0),
      .cmp_edge_i(ev[4]), .cmp_control_o(), .digital_input_disable_o());

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One request, then an idle cycle so its answer is visible
   task automatic op1(input iord_op_type o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
      u_core.io(o, a, b, d);
      u_core.io(IORD_OP_NONE, 8'h00, 3'h0, 8'h00);
   endtask : op1

   task automatic rd(input iord_op_type o, input logic [7:0] a, input logic [7:0] exp);
      op1(o, a, 3'h0, 8'h00);
      chk({rvalid, rdata}, {1'b1, exp});
   endtask : rd

   // One-cycle hardware event on a sticky flag
   task automatic pulse(input int i);
      @(negedge clock_i);
      ev[i] = 1'b1;
      @(negedge clock_i);
      ev[i] = 1'b0;
   endtask : pulse

   task automatic end_sim;
      $display("Checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim

   // Far beyond the fewer than two hundred cycles the tests need
   initial begin
      #100000;
      num_errors++;
      end_sim();
   end

   initial begin
      repeat (20) @(negedge clock_i);
      rst_i = 1'b0;
      rd(IORD_OP_IN, 8'h18, 8'h00);
      // Back-to-back write and read, then the data-space alias
      u_core.io(IORD_OP_OUT, 8'h18, 3'h0, 8'h5A);
      rd(IORD_OP_IN, 8'h18, 8'h5A);
      chk({1'b0, pb_out}, 9'h05A);
      rd(IORD_OP_LOAD, 8'h38, 8'h5A);
      op1(IORD_OP_STORE, 8'h35, 3'h0, 8'hC3);
      rd(IORD_OP_IN, 8'h15, 8'hC3);
      rd(IORD_OP_LOAD, 8'h36, 8'hA5);
      op1(IORD_OP_STORE, 8'h37, 3'h0, 8'h69);
      chk({1'b0, pb_dir}, 9'h069);
      op1(IORD_OP_LOAD, 8'h10, 3'h0, 8'h00);
      chk({8'h00, rvalid}, 9'h000);
      rd(IORD_OP_IN, 8'h0C, 8'h5A);
      op1(IORD_OP_OUT, 8'h0C, 3'h0, 8'h96);
      chk({1'b0, tx_data}, 9'h096);
      // Unimplemented bits and slots read zero
      op1(IORD_OP_OUT, 8'h1B, 3'h0, 8'hFF);
      rd(IORD_OP_IN, 8'h1B, 8'h07);
      chk({6'h00, pa_out}, 9'h007);
      rd(IORD_OP_IN, 8'h10, 8'h25);
      op1(IORD_OP_OUT, 8'h05, 3'h0, 8'h3C);
      chk({8'h00, aerr}, 9'h001);
      rd(IORD_OP_IN, 8'h05, 8'h00);
      // Single-bit set and clear, then the upper half refuses a set and a skip
      op1(IORD_OP_SET, 8'h12, 3'h6, 8'h00);
      op1(IORD_OP_SET, 8'h12, 3'h0, 8'h00);
      op1(IORD_OP_CLEAR, 8'h12, 3'h6, 8'h00);
      chk({2'b00, pd_out}, 9'h001);
      op1(IORD_OP_SET, 8'h21, 3'h0, 8'h00);
      chk({8'h00, aerr}, 9'h001);
      op1(IORD_OP_SKIP_ONE, 8'h36, 3'h0, 8'h00);
      chk({6'h00, aerr, svalid, skip}, 9'h006);
      // Both skip tests on every pin bit
      for (int i = 0; i < 8; i++) begin
         op1(IORD_OP_SKIP_ONE, 8'h16, 3'(i), 8'h00);
         chk({7'h00, svalid, skip}, {7'h00, 1'b1, pins_b[i]});
         op1(IORD_OP_SKIP_ZERO, 8'h16, 3'(i), 8'h00);
         chk({7'h00, svalid, skip}, {7'h00, 1'b1, ~pins_b[i]});
      end
      // Sticky flags: zero and bit-clear keep them, a written one clears
      for (int i = 0; i < 5; i++) begin
         pulse(i);
         rd(IORD_OP_IN, flag_addr[i], 8'h01 << flag_bit[i]);
         op1(IORD_OP_CLEAR, flag_addr[i], flag_bit[i], 8'h00);
         op1(IORD_OP_OUT, flag_addr[i], 3'h0, 8'h00);
         rd(IORD_OP_IN, flag_addr[i], 8'h01 << flag_bit[i]);
         op1(IORD_OP_SET, flag_addr[i], flag_bit[i], 8'h00);
         rd(IORD_OP_IN, flag_addr[i], 8'h00);
      end
      // Setting a neighbour bit must not clear a pending flag
      pulse(0);
      op1(IORD_OP_SET, 8'h0B, 3'h0, 8'h00);
      rd(IORD_OP_IN, 8'h0B, 8'h41);
      // A written one clears the flag, unless an event lands in the same cycle
      op1(IORD_OP_OUT, 8'h0B, 3'h0, 8'h40);
      rd(IORD_OP_IN, 8'h0B, 8'h00);
      chk({8'h00, tx_flag}, 9'h000);
      u_core.io(IORD_OP_OUT, 8'h0B, 3'h0, 8'h40);
      ev[0] = 1'b1;
      u_core.io(IORD_OP_NONE, 8'h00, 3'h0, 8'h00);
      ev[0] = 1'b0;
      rd(IORD_OP_IN, 8'h0B, 8'h40);
      chk({8'h00, tx_flag}, 9'h001);
      end_sim();
   end
endmodule : tb_iord_top
